// [rtl/sorl_top.sv]
// Purpose: Release and restart logic driving two redundant safety outputs
// Assumes: Pins asynchronous; non-volatile store supplies error at power-up
// Notes: Serial decoding is outside; commands arrive as one-cycle pulses
`timescale 1ns/1ps
module sorl_top #(
  parameter int unsigned BLINK_HALF = sorl_pkg::BLINK_HALF_CYC,
  parameter int unsigned DISC_WINDOW = sorl_pkg::DISC_WINDOW_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic manual_reset_variant_i,
  input wire logic chain_monitor_en_i,
  input wire logic guard_closed_i,
  input wire logic feedback_closed_i,
  input wire logic reset_button_i,
  input wire logic ack_button_i,
  input wire logic safety_input_a_i,
  input wire logic safety_input_b_i,
  input wire logic nv_error_valid_i,
  input wire logic nv_error_i,
  input wire logic serial_ack_i,
  input wire logic req_err_reset_i,
  output logic nv_error_we_o,
  output logic nv_error_o,
  output sorl_pkg::sorl_outs_s outs_o
);
  import sorl_pkg::*;

  sorl_pins_s pins_raw;
  sorl_pins_s pins;
  sorl_state_e state_r;
  sorl_state_e state_nxt;
  logic [31:0] blink_cnt_r;
  logic blink_r;
  logic [31:0] disc_cnt_r;
  logic disc_run_r;
  logic err_r;
  logic err_nxt;
  logic nv_loaded_r;
  logic nv_we_r;
  logic rst_btn_d_r;
  logic ack_btn_d_r;
  logic req_bit_d_r;
  logic guard_d_r;
  sorl_outs_s outs_r;
  sorl_outs_s outs_nxt;

  assign pins_raw = '{guard_closed: guard_closed_i,
                      feedback_closed: feedback_closed_i,
                      reset_button: reset_button_i,
                      ack_button: ack_button_i,
                      safety_input_a: safety_input_a_i,
                      safety_input_b: safety_input_b_i};

  sorl_sync #(
    .WIDTH($bits(sorl_pins_s))
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(pins_raw),
    .q_o(pins)
  );

  // Edge detection on synchronised levels; history resets to idle low
  wire rst_btn_fall = rst_btn_d_r & ~pins.reset_button; // R3
  wire ack_btn_fall = ack_btn_d_r & ~pins.ack_button; // R7
  // Request bit is same-clock, so it skips the synchroniser
  wire req_reset_fall = req_bit_d_r & ~req_err_reset_i; // R9
  wire guard_open_edge = guard_d_r & ~pins.guard_closed; // R9

  // Input pair; release needs the guard and both channels live
  wire both_on = pins.safety_input_a & pins.safety_input_b;
  wire one_off = pins.safety_input_a ^ pins.safety_input_b;
  wire release_ok = pins.guard_closed & both_on;

  // Discrepancy: window expired while only one input has dropped
  wire disc_timeout = disc_run_r & one_off &
                      (disc_cnt_r >= DISC_WINDOW); // R4
  wire disc_fault = chain_monitor_en_i & disc_timeout;
  wire ack_event = ack_btn_fall | serial_ack_i; // R7
  wire clear_event = req_reset_fall | guard_open_edge; // R9

  // Error flag: new discrepancy wins over a simultaneous acknowledge
  always_comb begin
    err_nxt = err_r;
    // Store value taken once, on its first valid cycle
    if (!nv_loaded_r && nv_error_valid_i) begin
      err_nxt = nv_error_i; // R6
    end else if (disc_fault) begin
      err_nxt = 1'b1; // R4
    end else if (ack_event || clear_event) begin
      err_nxt = 1'b0; // R5
    end
  end

  // Release state machine
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SORL_ST_OFF: begin
        if (release_ok && !err_r && pins.feedback_closed) begin
          if (manual_reset_variant_i) begin
            state_nxt = SORL_ST_ARMED; // R3
          end else begin
            state_nxt = SORL_ST_ON; // R2
          end
        end
      end
      SORL_ST_ARMED: begin
        // Arm drops back if feedback opens before the edge
        if (!release_ok || !pins.feedback_closed) begin
          state_nxt = SORL_ST_OFF;
        end else if (rst_btn_fall) begin
          state_nxt = SORL_ST_ON; // R3
        end
      end
      SORL_ST_ON: begin
        // Losing guard or either input drops both channels
        if (!release_ok) begin
          state_nxt = SORL_ST_OFF;
        end
      end
      default: begin
        // Error state left only once the flag is cleared
        if (!err_r) begin
          state_nxt = SORL_ST_OFF; // R5
        end
      end
    endcase
    if (err_nxt) begin
      state_nxt = SORL_ST_ERR; // R5
    end
  end

  // State, error and edge history
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= SORL_ST_OFF; // R1
      err_r <= RST_ERR_VALUE;
      nv_loaded_r <= 1'b0;
      rst_btn_d_r <= 1'b0;
      ack_btn_d_r <= 1'b0;
      req_bit_d_r <= 1'b0;
      guard_d_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      err_r <= err_nxt;
      nv_loaded_r <= nv_loaded_r | nv_error_valid_i;
      rst_btn_d_r <= pins.reset_button;
      ack_btn_d_r <= pins.ack_button;
      req_bit_d_r <= req_err_reset_i;
      guard_d_r <= pins.guard_closed;
    end
  end

  // Write-back pulse on any change so power loss keeps the error
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      nv_we_r <= 1'b0;
    end else begin
      // The load from the store itself never writes back
      nv_we_r <= nv_loaded_r & (err_nxt != err_r); // R6
    end
  end

  // Discrepancy timer runs from first input off to second
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      disc_run_r <= 1'b0;
      disc_cnt_r <= '0;
    end else if (one_off) begin
      disc_run_r <= 1'b1; // R10
      // Saturates at the window so a long skew never wraps
      if (disc_cnt_r < DISC_WINDOW) begin
        disc_cnt_r <= disc_cnt_r + 32'h1; // R10
      end
    end else begin
      disc_run_r <= 1'b0; // R10
      disc_cnt_r <= '0; // R10
    end
  end

  // Blink generator for the waiting indication
  // Free-running; only output selection decides if it shows
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      blink_cnt_r <= '0;
      blink_r <= 1'b0;
    end else if (blink_cnt_r >= BLINK_HALF - 1) begin
      blink_cnt_r <= '0;
      blink_r <= ~blink_r; // R1
    end else begin
      blink_cnt_r <= blink_cnt_r + 32'h1;
    end
  end

  // Output selection as named wires so the register process stays short
  wire release_nxt = (state_nxt == SORL_ST_ON); // R2
  // Waiting indication only while release is possible and no error
  wire waiting_nxt = release_ok & (state_nxt != SORL_ST_ERR); // R1
  // Steady when released, blinking while waiting, dark otherwise
  wire yellow_nxt = release_nxt | (waiting_nxt & blink_r); // R1 R2

  // Both channels come from the same decoded state, never two paths
  assign outs_nxt = '{safety_output_a: release_nxt,
                      safety_output_b: release_nxt,
                      yellow_led: yellow_nxt,
                      disc_error: err_nxt}; // R2 R5

  // Registered outputs; a glitch on the decode never reaches a pin
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      outs_r <= '0; // R1
    end else begin
      outs_r <= outs_nxt;
    end
  end

  assign outs_o = outs_r;
  assign nv_error_o = err_r;
  assign nv_error_we_o = nv_we_r;
endmodule

// [rtl/sorl_pkg.sv]
// Purpose: Shared constants and types for the safety output release logic
// Assumes: 200 MHz clk_i, asynchronous active-high reset
// Notes: Non-volatile error store sits outside; this block loads/saves it
//
// Summary of operation
// [R1] Power-up with open feedback: outputs off, 5 Hz blink
// [R2] Auto variant: feedback closing enables outputs, yellow steady
// [R3] Manual variant: enable only on reset button falling edge
// [R4] Chain monitor: inputs off >500 ms apart disables outputs
// [R5] Discrepancy error blocks re-enable until acknowledged
// [R6] Latched error kept in non-volatile storage
// [R7] Acknowledge by button falling edge or serial command
// [R8] Installation provides reset button with e-stop elements
// [R9] Request bit 7 one-to-zero or guard open clears fault
// [R10] Timer starts at first input off, cleared by second
package sorl_pkg;

  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned BLINK_HZ = 5;
  // Half period of the blink, toggled twice per blink cycle
  localparam int unsigned BLINK_HALF_CYC = CLK_HZ / (2 * BLINK_HZ);
  localparam int unsigned DISC_WINDOW_MS = 500;
  localparam int unsigned DISC_WINDOW_CYC = (CLK_HZ / 1000) * DISC_WINDOW_MS;
  localparam int unsigned REQ_ERR_RESET_BIT = 7;
  localparam logic RST_ERR_VALUE = 1'b0;

  typedef enum logic [1:0] {
    SORL_ST_OFF = 2'b00,
    SORL_ST_ARMED = 2'b01,
    SORL_ST_ON = 2'b10,
    SORL_ST_ERR = 2'b11
  } sorl_state_e;

  // Synchronised pin levels seen by the control logic
  typedef struct packed {
    logic guard_closed;
    logic feedback_closed;
    logic reset_button;
    logic ack_button;
    logic safety_input_a;
    logic safety_input_b;
  } sorl_pins_s;

  // Pin outputs of the block
  typedef struct packed {
    logic safety_output_a;
    logic safety_output_b;
    logic yellow_led;
    logic disc_error;
  } sorl_outs_s;

endpackage

// [rtl/sorl_sync.sv]
// Purpose: Two flip-flop synchroniser for a vector of pin levels
// Assumes: Inputs asynchronous to clk_i
// Notes: First stage is read only by the second stage
`timescale 1ns/1ps
module sorl_sync #(
  parameter int unsigned WIDTH = 6
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] q_r;

  // Two stages, reset low so outputs start disabled
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= d_i;
      q_r <= meta_r;
    end
  end

  assign q_o = q_r;
endmodule

// [sim/sorl_chk.sv]
// Purpose: Port assertions for sorl_top
// Assumes: Pin changes reach outputs 3 to 4 edges later
// Notes: Bound to sorl_top after the module
`timescale 1ns/1ps
module sorl_chk #(
  parameter int unsigned BLINK_HALF = 10,
  parameter int unsigned DISC_WINDOW = 50
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic manual_reset_variant_i,
  input wire logic chain_monitor_en_i,
  input wire logic guard_closed_i,
  input wire logic feedback_closed_i,
  input wire logic reset_button_i,
  input wire logic safety_input_a_i,
  input wire logic safety_input_b_i,
  input wire logic nv_error_we_o,
  input wire logic nv_error_o,
  input wire sorl_pkg::sorl_outs_s outs_o
);
  import sorl_pkg::*;
  logic [15:0] mis_r;
  // Release needs guard and both inputs; skew is a one-sided drop
  wire live = guard_closed_i & safety_input_a_i & safety_input_b_i;
  wire skew = chain_monitor_en_i & (safety_input_a_i ^ safety_input_b_i);
  wire on = outs_o.safety_output_a;
  wire rb = reset_button_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Skew length at the raw pins, so margin covers the synchroniser
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mis_r <= 16'h0;
    end else begin
      mis_r <= skew ? mis_r + 16'h1 : 16'h0;
    end
  end
  chk_outs_paired: assert property (on == outs_o.safety_output_b)
    else $error("outputs differ");
  chk_err_blocks: assert property (outs_o.disc_error |-> !on)
    else $error("on with error");
  chk_live_need: assert property (
    on |-> $past(live, 3) || $past(live, 4)) else $error("on without live");
  chk_auto_on: assert property (
    (!manual_reset_variant_i && live && feedback_closed_i && !nv_error_o)[*6]
    |-> on) else $error("no auto release");
  chk_manual_edge: assert property (
    $rose(on) && manual_reset_variant_i |-> $past(rb, 4) || $past(rb, 5))
    else $error("manual release without button");
  chk_disc_time: assert property (
    mis_r == 16'(DISC_WINDOW + 6) |-> outs_o.disc_error)
    else $error("skew not flagged");
  chk_nv_store: assert property (
    $rose(nv_error_o) && skew |-> ##[0:3] nv_error_we_o)
    else $error("error not stored");
  chk_we_pulse: assert property (nv_error_we_o |=> !nv_error_we_o)
    else $error("store write too long");
  // Main scenarios reached
  cover property ($rose(on));
  cover property ($rose(outs_o.disc_error));
  cover property ($fell(outs_o.disc_error));
endmodule
bind sorl_top sorl_chk #(.BLINK_HALF(BLINK_HALF), .DISC_WINDOW(DISC_WINDOW))
  i_sorl_chk (.clk_i, .rst_i, .manual_reset_variant_i, .chain_monitor_en_i,
  .guard_closed_i, .feedback_closed_i, .reset_button_i, .safety_input_a_i,
  .safety_input_b_i, .nv_error_we_o, .nv_error_o, .outs_o);

// [sim/sorl_field.sv]
// Purpose: Field side: guard, feedback, buttons, sensor chain
// Assumes: Bench sets the wanted levels in want_i
// Notes: Buttons are wired in, so release edges reach the block
`timescale 1ns/1ps
module sorl_field (
  input wire logic clk_i,
  input wire sorl_pkg::sorl_pins_s want_i,
  output sorl_pkg::sorl_pins_s pins_o
);
  import sorl_pkg::*;
  // Pins move on the falling edge only; one process drives them
  always @(negedge clk_i) pins_o <= want_i;
endmodule

// [sim/tb_top.sv]
// Purpose: Self-checking bench for sorl_top
// Assumes: Blink half period 10, skew window 50 cycles
// Notes: Drivers queue notes; a monitor compares them
`timescale 1ns/1ps
module tb_top;
  import sorl_pkg::*;
  localparam int BH = 10;
  localparam int DW = 50;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic manual_reset_variant_i = 1'h0;
  logic chain_monitor_en_i = 1'h0;
  logic nv_error_valid_i = 1'h1; // Store answers from power-up on
  logic nv_error_i = 1'h0;
  logic serial_ack_i = 1'h0;
  logic req_err_reset_i = 1'h0;
  logic nv_error_we_o, nv_error_o, y;
  logic [31:0] rnd = 32'h6974;
  logic [7:0] q[$];
  sorl_pins_s w = '0;
  sorl_pins_s p;
  sorl_outs_s outs_o;
  int n_mismatch = 0;
  int tests_run = 0;
  event chk;
  int n_we = 0;
  // 200 MHz clock
  initial forever #2.5 clk_i = ~clk_i;
  sorl_field i_sorl_field (.clk_i, .want_i(w), .pins_o(p));
  sorl_top #(.BLINK_HALF(BH), .DISC_WINDOW(DW)) i_sorl_top (.clk_i, .rst_i,
    .manual_reset_variant_i, .chain_monitor_en_i,
    .guard_closed_i(p.guard_closed), .feedback_closed_i(p.feedback_closed),
    .reset_button_i(p.reset_button), .ack_button_i(p.ack_button),
    .safety_input_a_i(p.safety_input_a), .safety_input_b_i(p.safety_input_b),
    .nv_error_valid_i, .nv_error_i, .serial_ack_i, .req_err_reset_i,
    .nv_error_we_o, .nv_error_o, .outs_o);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // Outputs under a mask against the expected bits
  task automatic cmp_outs(input logic [7:0] n);
    tests_run++;
    if ((outs_o & n[7:4]) !== n[3:0]) begin
      n_mismatch++;
      $display("[FAIL] %0t outs %b want %b", $time, outs_o, n[3:0]);
    end
  endtask
  task automatic note(input logic [3:0] m, input logic [3:0] e, input int c);
    repeat (c) @(negedge clk_i);
    q.push_back({m, e});
    ->chk;
  endtask
  // Monitor takes the oldest note once outputs settle
  initial forever begin
    @(chk);
    #1 cmp_outs(q.pop_front());
  end
  // Store write pulses stand one cycle, so one falling edge sees each
  always @(negedge clk_i) begin
    if (nv_error_we_o === 1'h1) n_we++;
  end
  // Store writes against error sets and clears, plus the stored level
  task automatic cmp_we(input int e, input logic lvl);
    tests_run++;
    if (n_we != e || nv_error_o !== lvl) begin
      n_mismatch++;
      $display("[FAIL] %0t store writes %0d want %0d", $time, n_we, e);
    end
  endtask
  task automatic print_verdict();
    $display("tests_run %0d n_mismatch %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Tests need about 500 cycles; cut a hang well beyond that
  initial begin
    #20000;
    n_mismatch++;
    print_verdict();
  end
  // Wanted pin levels set on the rising edge, model moves them on the falling edge
  task automatic pin(input logic [5:0] v, input int c);
    @(posedge clk_i);
    w = v;
    repeat (c) @(negedge clk_i);
  endtask
  task automatic rst(input logic m);
    @(negedge clk_i);
    rst_i = 1'h1;
    manual_reset_variant_i = m;
    repeat (2) @(negedge clk_i);
    rst_i = 1'h0;
  endtask
  initial begin
    rst(1'h0);
    chain_monitor_en_i = 1'h1;
    pin(6'h23, 8);
    y = outs_o.yellow_led;
    note(4'hE, {2'h0, ~y, 1'h0}, BH);
    $display("test blink done");
    pin(6'h33, 0);
    note(4'hF, 4'hE, 6);
    rnd = xs(rnd);
    pin(6'h32, rnd % 30 + 1);
    pin(6'h30, 0);
    note(4'hF, 4'h0, 6);
    pin(6'h33, 0);
    note(4'hF, 4'hE, 6);
    $display("test release done");
    for (int c = 0; c < 4; c++) begin
      rnd = xs(rnd);
      pin(rnd[0] ? 6'h31 : 6'h32, 0);
      note(4'hF, 4'h1, DW + 8);
      pin(6'h33, 0);
      note(4'hF, 4'h1, 6);
      if (c == 0) pin(6'h37, 4);
      if (c == 1) serial_ack_i = 1'h1;
      if (c == 2) req_err_reset_i = 1'h1;
      if (c == 3) pin(6'h13, 4);
      pin(6'h33, 1);
      {serial_ack_i, req_err_reset_i} = 2'h0;
      note(4'hF, 4'hE, 8);
    end
    cmp_we(8, 1'h0);
    $display("test error done");
    chain_monitor_en_i = 1'h0;
    pin(6'h31, 0);
    note(4'hF, 4'h0, DW + 8);
    pin(6'h33, 0);
    note(4'hF, 4'hE, 6);
    $display("test monitor off done");
    rst(1'h1);
    note(4'hD, 4'h0, 8);
    pin(6'h3B, 4);
    pin(6'h33, 0);
    note(4'hF, 4'hE, 8);
    $display("test manual done");
    nv_error_i = 1'h1;
    rst(1'h0);
    note(4'hF, 4'h1, 8);
    cmp_we(8, 1'h1);
    $display("test store done");
    repeat (2) @(negedge clk_i);
    print_verdict();
  end
endmodule
